// ### hw/mmfr2_pkg.sv
// Constants and types for the memory model feature identification register
package mmfr2_pkg;

    localparam int REG_W       = 64;
    localparam int FIELD_W     = 4;
    localparam int FIELD_COUNT = 16;

    // Field values, listed from bits 63:60 down to bits 3:0
    localparam logic [3:0] HIDDEN_REGION_FAULT_VAL    = 4'h1;
    localparam logic [3:0] EXTRA_HYPERVISOR_TRAPS_VAL = 4'h2;
    localparam logic [3:0] BLOCK_RESIZE_LEVEL_VAL     = 4'h2;
    localparam logic [3:0] TLB_LEVEL_HINT_VAL         = 4'h1;
    localparam logic [3:0] RESERVED_VAL               = 4'h0;
    localparam logic [3:0] FORCED_WRITE_BACK_VAL      = 4'h1;
    localparam logic [3:0] ID_SPACE_TRAP_CLASS_VAL    = 4'h1;
    localparam logic [3:0] SINGLE_COPY_UNALIGNED_VAL  = 4'h1;
    localparam logic [3:0] SMALL_TABLE_SUPPORT_VAL    = 4'h1;
    localparam logic [3:0] NESTED_VIRTUALIZATION_VAL  = 4'h0;
    localparam logic [3:0] CACHE_SIZE_ID_FORMAT_VAL   = 4'h1;
    localparam logic [3:0] VIRTUAL_ADDR_WIDTH_VAL     = 4'h0;
    localparam logic [3:0] IMPLICIT_ERROR_BARRIER_VAL = 4'h1;
    localparam logic [3:0] MULTIPLE_LOAD_ORDER_VAL    = 4'h0;
    localparam logic [3:0] USER_OVERRIDE_SUPPORT_VAL  = 4'h1;
    localparam logic [3:0] SHARED_TRANSLATION_VAL     = 4'h1;

    // Entry i sits at bits i*FIELD_W upward
    localparam logic [FIELD_COUNT-1:0][3:0] FIELD_TABLE = {
        HIDDEN_REGION_FAULT_VAL, EXTRA_HYPERVISOR_TRAPS_VAL,
        BLOCK_RESIZE_LEVEL_VAL, TLB_LEVEL_HINT_VAL,
        RESERVED_VAL, FORCED_WRITE_BACK_VAL,
        ID_SPACE_TRAP_CLASS_VAL, SINGLE_COPY_UNALIGNED_VAL,
        SMALL_TABLE_SUPPORT_VAL, NESTED_VIRTUALIZATION_VAL,
        CACHE_SIZE_ID_FORMAT_VAL, VIRTUAL_ADDR_WIDTH_VAL,
        IMPLICIT_ERROR_BARRIER_VAL, MULTIPLE_LOAD_ORDER_VAL,
        USER_OVERRIDE_SUPPORT_VAL, SHARED_TRANSLATION_VAL};

    // Read encoding of this register
    localparam logic [1:0] SEL_OP0 = 2'h3;
    localparam logic [2:0] SEL_OP1 = 3'h0;
    localparam logic [3:0] SEL_CRN = 4'h0;
    localparam logic [3:0] SEL_CRM = 4'h7;
    localparam logic [2:0] SEL_OP2 = 3'h2;

    localparam logic [5:0] SYNDROME_CLASS_SYSREG = 6'h18;
    localparam logic [5:0] SYNDROME_CLASS_NONE   = 6'h00;

    typedef enum logic [1:0] {
        USER_LEVEL       = 2'b00,
        KERNEL_LEVEL     = 2'b01,
        HYPERVISOR_LEVEL = 2'b10,
        MONITOR_LEVEL    = 2'b11
    } privilege_level_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] op0;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
    } sysreg_req_t;

    typedef struct packed {
        privilege_level_t current_privilege_level;
        logic             hypervisor_enabled;
        logic             host_trap_general;
        logic             id_group3_trap;
    } trap_ctrl_t;

    typedef struct packed {
        logic             valid;
        logic             hit;
        logic             trap;
        privilege_level_t target_level;
        logic [5:0]       syndrome_class;
        logic [REG_W-1:0] data;
    } sysreg_resp_t;

endpackage

// ### hw/mmfr2_access_check.sv
// Privilege check that decides between returning the value and trapping
`timescale 1ns/1ps
module mmfr2_access_check (
    input  wire mmfr2_pkg::trap_ctrl_t       ctrl_in,
    output logic                             trap_out,
    output mmfr2_pkg::privilege_level_t      target_out
);
    import mmfr2_pkg::*;

    wire hyp_route_user   = ctrl_in.hypervisor_enabled && ctrl_in.host_trap_general;
    wire hyp_route_kernel = ctrl_in.hypervisor_enabled && ctrl_in.id_group3_trap;
    wire at_user   = ctrl_in.current_privilege_level == USER_LEVEL;
    wire at_kernel = ctrl_in.current_privilege_level == KERNEL_LEVEL;

    // User reads always trap; hypervisor and monitor never do
    assign trap_out = at_user || (at_kernel && hyp_route_kernel);

    assign target_out = (at_user && !hyp_route_user) ? KERNEL_LEVEL
                                                     : HYPERVISOR_LEVEL;

endmodule

// ### hw/mmfr2_read_unit.sv
// Read port, decode and access check for the memory model feature register
`timescale 1ns/1ps
module mmfr2_read_unit (
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   clk_en_in,
    input  wire mmfr2_pkg::sysreg_req_t req_in,
    input  wire mmfr2_pkg::trap_ctrl_t  ctrl_in,
    output mmfr2_pkg::sysreg_resp_t     resp_out
);
    import mmfr2_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Constant register image

    wire [REG_W-1:0] reg_value_w;

    // No write path exists, so the image is pure wiring
    generate
        for (genvar g = 0; g < FIELD_COUNT; g++) begin : g_field
            assign reg_value_w[g*FIELD_W +: FIELD_W] = FIELD_TABLE[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Encoding decode

    wire enc_match = (req_in.op0 == SEL_OP0) &&
                     (req_in.op1 == SEL_OP1) &&
                     (req_in.crn == SEL_CRN) &&
                     (req_in.crm == SEL_CRM) &&
                     (req_in.op2 == SEL_OP2);
    wire read_hit = req_in.valid && enc_match;

    ////////////////////////////////////////////////////////////////////////
    // Access check

    logic             trap_w;
    privilege_level_t target_w;

    mmfr2_access_check u_check (
        .ctrl_in    (ctrl_in),
        .trap_out   (trap_w),
        .target_out (target_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Response register

    wire sysreg_resp_t resp_d;
    sysreg_resp_t      resp_q;

    // Trapped reads must not leak the value, so data is zeroed
    wire give_data = read_hit && !trap_w;
    wire give_trap = read_hit && trap_w;

    assign resp_d.valid          = req_in.valid;
    assign resp_d.hit            = read_hit;
    assign resp_d.trap           = give_trap;
    assign resp_d.target_level   = give_trap ? target_w : USER_LEVEL;
    assign resp_d.syndrome_class = give_trap ? SYNDROME_CLASS_SYSREG
                                             : SYNDROME_CLASS_NONE;
    assign resp_d.data           = give_data ? reg_value_w : '0;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            resp_q <= '0;
        end else if (clk_en_in) begin
            resp_q <= resp_d;
        end
    end

    assign resp_out = resp_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // Helper: last data value seen, for the constancy check
    logic [REG_W-1:0] seen_data_q;
    logic             seen_any_q;
    wire data_seen = resp_q.valid && resp_q.hit && !resp_q.trap;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            seen_data_q <= '0;
            seen_any_q  <= 1'b0;
        end else if (data_seen) begin
            seen_data_q <= resp_q.data;
            seen_any_q  <= 1'b1;
        end
    end

    sequence s_take;
        clk_en_in && req_in.valid && enc_match;
    endsequence

    sequence s_user_read;
        s_take ##0 ctrl_in.current_privilege_level == USER_LEVEL;
    endsequence

    sequence s_kernel_read;
        s_take ##0 ctrl_in.current_privilege_level == KERNEL_LEVEL;
    endsequence

    sequence s_high_read;
        s_take ##0 (ctrl_in.current_privilege_level == HYPERVISOR_LEVEL ||
                    ctrl_in.current_privilege_level == MONITOR_LEVEL);
    endsequence

    a_field_hidden: assert property (data_seen |-> resp_q.data[63:60] == 4'h1)
        else $error("hidden region fault field wrong");

    a_field_extra_traps: assert property (data_seen |-> resp_q.data[59:56] == 4'h2)
        else $error("extra hypervisor trap field wrong");

    a_field_block_resize: assert property (data_seen |-> resp_q.data[55:52] == 4'h2)
        else $error("block resize field wrong");

    a_field_level_hint: assert property (data_seen |-> resp_q.data[51:48] == 4'h1)
        else $error("level hint field wrong");

    a_field_reserved: assert property (data_seen |-> resp_q.data[47:44] == 4'h0)
        else $error("reserved field not zero");

    a_field_write_back: assert property (data_seen |-> resp_q.data[43:40] == 4'h1)
        else $error("forced write back field wrong");

    a_trap_class_field: assert property (data_seen |-> resp_q.data[39:36] == 4'h1)
        else $error("id space trap class field wrong");

    a_trap_class_value: assert property (resp_q.trap |-> resp_q.syndrome_class == 6'h18)
        else $error("trap syndrome class not 0x18");

    a_field_atomicity: assert property (data_seen |-> resp_q.data[35:32] == 4'h1)
        else $error("unaligned atomicity field wrong");

    a_field_small_table: assert property (data_seen |-> resp_q.data[31:28] == 4'h1)
        else $error("small table field wrong");

    a_field_nested_virt: assert property (data_seen |-> resp_q.data[27:24] == 4'h0)
        else $error("nested virtualization field wrong");

    a_field_cache_format: assert property (data_seen |-> resp_q.data[23:20] == 4'h1)
        else $error("cache size format field wrong");

    a_field_va_width: assert property (data_seen |-> resp_q.data[19:16] == 4'h0)
        else $error("virtual address width field wrong");

    a_field_error_barrier: assert property (data_seen |-> resp_q.data[15:12] == 4'h1)
        else $error("error barrier field wrong");

    a_field_load_order: assert property (data_seen |-> resp_q.data[11:8] == 4'h0)
        else $error("load order field wrong");

    a_field_user_override: assert property (data_seen |-> resp_q.data[7:4] == 4'h1)
        else $error("user override field wrong");

    a_field_shared_trans: assert property (data_seen |-> resp_q.data[3:0] == 4'h1)
        else $error("shared translation field wrong");

    a_decode_miss: assert property (
        clk_en_in && req_in.valid && req_in.op2 != 3'h2 |=> resp_q.valid && !resp_q.hit)
        else $error("wrong op2 selected the register");

    a_decode_hit: assert property (
        clk_en_in && req_in.valid && req_in.op0 == 2'h3 && req_in.op1 == 3'h0 &&
        req_in.crn == 4'h0 && req_in.crm == 4'h7 && req_in.op2 == 3'h2
        |=> resp_q.valid && resp_q.hit)
        else $error("register encoding not selected");

    a_user_to_hyp: assert property (
        s_user_read ##0 (ctrl_in.hypervisor_enabled && ctrl_in.host_trap_general)
        |=> resp_q.trap && resp_q.target_level == HYPERVISOR_LEVEL)
        else $error("user read not routed to hypervisor");

    a_user_to_kernel: assert property (
        s_user_read ##0 !(ctrl_in.hypervisor_enabled && ctrl_in.host_trap_general)
        |=> resp_q.trap && resp_q.target_level == KERNEL_LEVEL)
        else $error("user read not routed to kernel");

    a_kernel_trap: assert property (
        s_kernel_read ##0 (ctrl_in.hypervisor_enabled && ctrl_in.id_group3_trap)
        |=> resp_q.trap && resp_q.target_level == HYPERVISOR_LEVEL)
        else $error("kernel read did not trap");

    a_kernel_return: assert property (
        s_kernel_read ##0 !(ctrl_in.hypervisor_enabled && ctrl_in.id_group3_trap)
        |=> resp_q.hit && !resp_q.trap && resp_q.data != '0 &&
            (resp_q.data == seen_data_q || !seen_any_q))
        else $error("kernel read did not return value");

    a_high_no_trap: assert property (
        s_high_read |=> !resp_q.trap && resp_q.hit && resp_q.data[63:60] == 4'h1)
        else $error("high level read trapped");

    a_value_constant: assert property (
        data_seen && seen_any_q |-> resp_q.data == seen_data_q)
        else $error("register value changed");

    a_freeze_hold: assert property (
        !clk_en_in |=> $stable(resp_q))
        else $error("response changed while clock enable low");

    // Trapped reads must carry no register contents
    a_trap_no_data: assert property (
        resp_q.trap |-> resp_q.hit && resp_q.valid && resp_q.data == '0)
        else $error("trapped read carried data");

    a_miss_quiet: assert property (
        resp_q.valid && !resp_q.hit |->
        !resp_q.trap && resp_q.data == '0 && resp_q.syndrome_class == 6'h00)
        else $error("missed read not quiet");

    a_no_trap_class: assert property (
        !resp_q.trap |-> resp_q.syndrome_class == 6'h00 && resp_q.target_level == USER_LEVEL)
        else $error("class or target set without trap");

    a_idle_zero: assert property (
        !resp_q.valid |-> resp_q == '0)
        else $error("response not zero while idle");

    // Reset must win over a low clock enable
    a_reset_clear: assert property (
        disable iff (1'b0) rst_in |=> resp_q == '0)
        else $error("response not cleared by reset");

endmodule

// ### bench/tb.sv
// Self-checking bench for the memory model feature register read unit
`timescale 1ns/1ps
module tb;
    import mmfr2_pkg::*;

    localparam logic [63:0] FEATURE_VAL = 64'h1221_0111_1010_1011;

    logic         clk_in;
    logic         rst_in;
    logic         clk_en_in;
    sysreg_req_t  req_in;
    trap_ctrl_t   ctrl_in;
    sysreg_resp_t resp_out;
    sysreg_resp_t exp_q;
    logic [31:0]  lfsr_s;
    int           err_total;
    int           checked;

    mmfr2_read_unit dut (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .clk_en_in (clk_en_in),
        .req_in    (req_in),
        .ctrl_in   (ctrl_in),
        .resp_out  (resp_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic sysreg_req_t match_req(input logic v);
        sysreg_req_t r;
        r = {v, 2'h3, 3'h0, 4'h0, 4'h7, 3'h2};
        return r;
    endfunction

    function automatic trap_ctrl_t mk_ctrl(input logic [4:0] b);
        trap_ctrl_t c;
        c.current_privilege_level = privilege_level_t'(b[1:0]);
        c.hypervisor_enabled      = b[2];
        c.host_trap_general       = b[3];
        c.id_group3_trap          = b[4];
        return c;
    endfunction

    // Expected answer worked out from the encoding and the access rules
    function automatic sysreg_resp_t exp_resp(input sysreg_req_t q, input trap_ctrl_t c);
        sysreg_resp_t r;
        r = '0;
        if (q.valid) begin
            r.valid = 1'b1;
            r.hit   = (q.op0 == 2'h3) && (q.op1 == 3'h0) && (q.crn == 4'h0) &&
                      (q.crm == 4'h7) && (q.op2 == 3'h2);
            if (r.hit) begin
                if (c.current_privilege_level == USER_LEVEL) begin
                    r.trap         = 1'b1;
                    r.target_level = (c.hypervisor_enabled && c.host_trap_general) ?
                                     HYPERVISOR_LEVEL : KERNEL_LEVEL;
                end else if (c.current_privilege_level == KERNEL_LEVEL &&
                             c.hypervisor_enabled && c.id_group3_trap) begin
                    r.trap         = 1'b1;
                    r.target_level = HYPERVISOR_LEVEL;
                end
                if (r.trap) begin
                    r.syndrome_class = 6'h18;
                end else begin
                    r.data = FEATURE_VAL;
                end
            end
        end
        return r;
    endfunction

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_resp();
        check("valid", 64'(resp_out.valid), 64'(exp_q.valid));
        check("hit", 64'(resp_out.hit), 64'(exp_q.hit));
        check("trap", 64'(resp_out.trap), 64'(exp_q.trap));
        check("target", 64'(resp_out.target_level), 64'(exp_q.target_level));
        check("syndrome", 64'(resp_out.syndrome_class), 64'(exp_q.syndrome_class));
        check("data", resp_out.data, exp_q.data);
    endtask

    // One clock: look at the answer of the last edge, then present new inputs
    task automatic step(input sysreg_req_t q, input trap_ctrl_t c, input logic en,
                        input logic rs);
        @(posedge clk_in);
        #1;
        check_resp();
        req_in    = q;
        ctrl_in   = c;
        clk_en_in = en;
        rst_in    = rs;
        if (rs) begin
            exp_q = '0;
        end else if (en) begin
            exp_q = exp_resp(q, c);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Roughly 450 cycles of work; the limit leaves wide margin
    initial begin
        #(4 * 5000);
        err_total++;
        stop_test();
    end

    initial begin
        sysreg_req_t q;
        trap_ctrl_t  hyp;
        rst_in    = 1'b1;
        clk_en_in = 1'b1;
        req_in    = '0;
        ctrl_in   = '0;
        exp_q     = '0;
        lfsr_s    = 32'hb09d;
        err_total = 0;
        checked   = 0;
        hyp       = mk_ctrl(5'h1e);
        step(match_req(1'b1), hyp, 1'b1, 1'b1);
        step(match_req(1'b1), hyp, 1'b1, 1'b1);
        // Every level with every trap control, back to back
        for (int i = 0; i < 32; i++) begin
            step(match_req(1'b1), mk_ctrl(5'(i)), 1'b1, 1'b0);
        end
        // One bit wrong in each encoding field, then the neighbour register
        for (int k = 0; k < 6; k++) begin
            q = match_req(1'b1);
            case (k)
                0: q.op0 = 2'h2;
                1: q.op1 = 3'h1;
                2: q.crn = 4'h1;
                3: q.crm = 4'h6;
                4: q.op2 = 3'h3;
                default: q.op2 = 3'h1;
            endcase
            step(q, hyp, 1'b1, 1'b0);
        end
        // Hold with the enable low, then let the answer drop
        step(match_req(1'b1), hyp, 1'b1, 1'b0);
        step(match_req(1'b1), mk_ctrl(5'h00), 1'b0, 1'b0);
        step(match_req(1'b0), hyp, 1'b0, 1'b0);
        step(match_req(1'b0), hyp, 1'b1, 1'b0);
        step(match_req(1'b1), hyp, 1'b1, 1'b0);
        // Random traffic, mostly on the right encoding, with stray resets
        for (int n = 0; n < 400; n++) begin
            lfsr_s = lfsr_next(lfsr_s);
            q      = match_req(lfsr_s[0] | lfsr_s[1]);
            if (lfsr_s[4:2] == 3'h0) begin
                q = {q.valid, lfsr_s[31:16]};
            end
            step(q, mk_ctrl(lfsr_s[9:5]), lfsr_s[12] | lfsr_s[13] | lfsr_s[14],
                 lfsr_s[30:25] == 6'h00);
        end
        step(match_req(1'b0), hyp, 1'b1, 1'b0);
        step(match_req(1'b0), hyp, 1'b1, 1'b0);
        stop_test();
    end
endmodule
